// file: hw/rtp_pkg.sv
package rtp_pkg;
    // Word and station geometry
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned STN_W        = 7;
    localparam int unsigned STN_PER_LINE = 12;
    localparam int unsigned LINES        = 2;
    localparam int unsigned MAX_STN      = STN_PER_LINE * LINES;
    localparam int unsigned CNT_W        = 5;
    localparam int unsigned INFO_W       = 32;

    // System register range holding one timeout flag per station number
    localparam logic [11:0] SYS_FIRST    = 12'h380;
    localparam logic [11:0] SYS_LAST     = 12'h3ff;
    localparam int unsigned SYS_SPAN     = 128;

    // Output area: up to 256 bytes, i.e. 128 words
    localparam int unsigned BYTES_W      = 9;
    localparam int unsigned WADDR_W      = 7;
    localparam int unsigned WCNT_W       = 8;
    localparam int unsigned AREA_WORDS   = 128;

    // Station count above which a second status word is needed, and the largest station count used
    localparam logic [4:0]  ONE_WORD_MAX = 5'h10;
    localparam logic [4:0]  STN_LIMIT    = 5'h18;

    typedef enum logic [1:0] {RTP_IDLE, RTP_SEND} rtp_state_type;

    // Mirror the bit order of one 16-bit word
    function automatic logic [WORD_W-1:0] rtp_mirror(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_W; i++) begin
            r[i] = w[WORD_W-1-i];
        end
        return r;
    endfunction
endpackage

// file: hw/rtp_link_if.sv
`timescale 1ns/1ps
// Link between the slave module and the fieldbus master
interface rtp_link_if;
    logic                              req;    // Master asks for one output transfer
    logic                              wvalid; // Output word on wdata
    logic [rtp_pkg::WADDR_W-1:0]       waddr;  // Word index within the output area
    logic [rtp_pkg::WORD_W-1:0]        wdata;
    logic                              wlast;  // Transfer complete
    logic                              ivalid; // Input word from the master
    logic [rtp_pkg::WORD_W-1:0]        idata;

    modport dev  (input req, ivalid, idata, output wvalid, waddr, wdata, wlast);
    modport host (output req, ivalid, idata, input wvalid, waddr, wdata, wlast);
endinterface

// file: hw/rtp_slave.sv
`timescale 1ns/1ps
module rtp_slave (
    input  wire logic                                        mclk_i,
    input  wire logic                                        reset_n_i,
    input  wire logic                                        cfg_slave_mode_i,
    input  wire logic                                        cfg_collect_en_i,
    input  wire logic                                        cfg_bit_rev_i,
    input  wire logic [rtp_pkg::BYTES_W-1:0]                 cfg_out_bytes_i,
    input  wire logic [rtp_pkg::WADDR_W-1:0]                 cfg_info_word_i,
    input  wire logic [rtp_pkg::CNT_W-1:0]                   cfg_station_cnt_i,
    input  wire logic [rtp_pkg::MAX_STN*rtp_pkg::STN_W-1:0]  cfg_station_num_i,
    input  wire logic [rtp_pkg::SYS_SPAN-1:0]                sys_timeout_i,
    input  wire logic                                        out_wr_i,
    input  wire logic [rtp_pkg::WADDR_W-1:0]                 out_wr_addr_i,
    input  wire logic [rtp_pkg::WORD_W-1:0]                  out_wr_data_i,
    output logic                                             in_valid_o,
    output logic [rtp_pkg::WORD_W-1:0]                       in_data_o,
    output logic                                             busy_o,
    rtp_link_if.dev                                          lnk
);

    // Build the two status words from the registered station table
    function automatic logic [rtp_pkg::INFO_W-1:0] pack_timeouts(
        input logic [rtp_pkg::CNT_W-1:0]                   cnt,
        input logic [rtp_pkg::MAX_STN*rtp_pkg::STN_W-1:0]  table_v,
        input logic [rtp_pkg::SYS_SPAN-1:0]                flags);
        logic [rtp_pkg::INFO_W-1:0] w;
        logic [rtp_pkg::STN_W-1:0]  stn;
        w = '0;
        for (int k = 0; k < rtp_pkg::MAX_STN; k++) begin
            stn = table_v[k*rtp_pkg::STN_W +: rtp_pkg::STN_W];
            // Slot k maps to bit k; empty slots stay zero
            if (k < int'(cnt)) begin
                w[k] = flags[stn];
            end
        end
        return w;
    endfunction

    rtp_pkg::rtp_state_type             state_r;
    rtp_pkg::rtp_state_type             state_nxt;
    logic [rtp_pkg::WORD_W-1:0]         area_mem [rtp_pkg::AREA_WORDS];
    logic [rtp_pkg::INFO_W-1:0]         info_r;
    logic [rtp_pkg::WCNT_W-1:0]         idx_r;
    logic [rtp_pkg::WCNT_W-1:0]         idx_nxt;
    logic                               wvalid_r;
    logic [rtp_pkg::WADDR_W-1:0]        waddr_r;
    logic [rtp_pkg::WORD_W-1:0]         wdata_r;
    logic                               wlast_r;
    logic                               in_valid_r;
    logic [rtp_pkg::WORD_W-1:0]         in_data_r;

    wire  [rtp_pkg::CNT_W-1:0]          cnt_eff;
    wire                                two_words;
    wire  [rtp_pkg::WCNT_W-1:0]         n_words;
    wire  [rtp_pkg::WCNT_W-1:0]         info_end;
    wire                                info_fits;
    wire                                collect_on;
    wire                                hit_lo;
    wire                                hit_hi;
    wire                                at_last;
    wire                                start;
    wire  [rtp_pkg::WORD_W-1:0]         raw_word;
    wire  [rtp_pkg::WORD_W-1:0]         out_word;

    // A count above 24 cannot be registered, so clamp rather than index past the table
    assign cnt_eff    = (cfg_station_cnt_i > rtp_pkg::STN_LIMIT) ?
                        rtp_pkg::STN_LIMIT : cfg_station_cnt_i;
    assign two_words  = cnt_eff > rtp_pkg::ONE_WORD_MAX;

    // Area size in words; an odd byte count still occupies a full word
    assign n_words    = rtp_pkg::WCNT_W'((cfg_out_bytes_i + 9'h001) >> 1);

    // A misplaced info address is dropped instead of overwriting beyond the area
    assign info_end   = rtp_pkg::WCNT_W'({1'b0, cfg_info_word_i})
                        + (two_words ? 8'h02 : 8'h01);
    assign info_fits  = info_end <= n_words;

    // Collection only when configured and only while in slave mode
    assign collect_on = cfg_collect_en_i & cfg_slave_mode_i & info_fits;

    // Word selection for the current index
    assign hit_lo     = collect_on
                        & (idx_r == rtp_pkg::WCNT_W'({1'b0, cfg_info_word_i}));
    assign hit_hi     = collect_on & two_words
                        & (idx_r == rtp_pkg::WCNT_W'({1'b0, cfg_info_word_i}) + 8'h01);
    assign raw_word   = hit_lo ? info_r[15:0] :
                        hit_hi ? info_r[31:16] :
                        area_mem[idx_r[rtp_pkg::WADDR_W-1:0]];
    assign out_word   = cfg_bit_rev_i ? rtp_pkg::rtp_mirror(raw_word) : raw_word;

    assign at_last    = (idx_r + 8'h01) >= n_words;
    assign start      = (state_r == rtp_pkg::RTP_IDLE) & lnk.req;

    // Next state: a request while busy is ignored
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        unique case (state_r)
            rtp_pkg::RTP_IDLE: begin
                idx_nxt = '0;
                if (lnk.req && n_words != '0) begin
                    state_nxt = rtp_pkg::RTP_SEND;
                end
            end
            rtp_pkg::RTP_SEND: begin
                idx_nxt = idx_r + 8'h01;
                if (at_last) begin
                    state_nxt = rtp_pkg::RTP_IDLE;
                end
            end
        endcase
    end

    // Output area written by the controller side; no reset, contents are data
    always_ff @(posedge mclk_i) begin
        if (out_wr_i) begin
            area_mem[out_wr_addr_i] <= out_wr_data_i;
        end
    end

    // Snapshot flags at the request so both words describe one instant
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            info_r <= '0;
        end else if (start) begin
            info_r <= pack_timeouts(cnt_eff, cfg_station_num_i, sys_timeout_i);
        end
    end

    // Sequencer
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= rtp_pkg::RTP_IDLE;
            idx_r   <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // Registered link outputs; an empty area still ends with a bare wlast
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wvalid_r <= 1'b0;
            waddr_r  <= '0;
            wdata_r  <= '0;
            wlast_r  <= 1'b0;
        end else begin
            wvalid_r <= state_r == rtp_pkg::RTP_SEND;
            waddr_r  <= idx_r[rtp_pkg::WADDR_W-1:0];
            wdata_r  <= (state_r == rtp_pkg::RTP_SEND) ? out_word : '0;
            wlast_r  <= ((state_r == rtp_pkg::RTP_SEND) & at_last)
                        | (start & (n_words == '0));
        end
    end

    // Input words from the master, mirrored under bit reversal
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_valid_r <= 1'b0;
            in_data_r  <= '0;
        end else begin
            in_valid_r <= lnk.ivalid;
            in_data_r  <= cfg_bit_rev_i ? rtp_pkg::rtp_mirror(lnk.idata) : lnk.idata;
        end
    end

    assign lnk.wvalid = wvalid_r;
    assign lnk.waddr  = waddr_r;
    assign lnk.wdata  = wdata_r;
    assign lnk.wlast  = wlast_r;
    assign in_valid_o = in_valid_r;
    assign in_data_o  = in_data_r;
    assign busy_o     = wvalid_r;   // High while words are on the link

endmodule // rtp_slave

// file: hw/rtp_master.sv
`timescale 1ns/1ps
// Fieldbus master end: polls the slave and forwards input data to it
module rtp_master (
    input  wire logic                          mclk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          start_i,
    input  wire logic                          send_valid_i,
    input  wire logic [rtp_pkg::WORD_W-1:0]    send_data_i,
    output logic                               busy_o,
    output logic                               word_valid_o,
    output logic [rtp_pkg::WADDR_W-1:0]        word_addr_o,
    output logic [rtp_pkg::WORD_W-1:0]         word_data_o,
    output logic                               done_o,
    rtp_link_if.host                           lnk
);

    logic                             req_r;
    logic                             busy_r;
    logic                             wv_r;
    logic [rtp_pkg::WADDR_W-1:0]      wa_r;
    logic [rtp_pkg::WORD_W-1:0]       wd_r;
    logic                             done_r;
    logic                             iv_r;
    logic [rtp_pkg::WORD_W-1:0]       id_r;

    // One request pulse per transfer; start while busy is dropped
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_r  <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            req_r  <= start_i & ~busy_r;
            busy_r <= (busy_r & ~lnk.wlast) | (start_i & ~busy_r);
        end
    end

    // Received output words are handed to the user one cycle later
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wv_r   <= 1'b0;
            wa_r   <= '0;
            wd_r   <= '0;
            done_r <= 1'b0;
        end else begin
            wv_r   <= lnk.wvalid;
            wa_r   <= lnk.waddr;
            wd_r   <= lnk.wdata;
            done_r <= lnk.wlast & busy_r;
        end
    end

    // Input data towards the slave, registered onto the link
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            iv_r <= 1'b0;
            id_r <= '0;
        end else begin
            iv_r <= send_valid_i;
            id_r <= send_data_i;
        end
    end

    assign lnk.req      = req_r;
    assign lnk.ivalid   = iv_r;
    assign lnk.idata    = id_r;
    assign busy_o       = busy_r;
    assign word_valid_o = wv_r;
    assign word_addr_o  = wa_r;
    assign word_data_o  = wd_r;
    assign done_o       = done_r;

endmodule // rtp_master

// file: sim/rtp_asserts.sv
`timescale 1ns/1ps
// Watches the link between the two ends; sees only the interface signals
module rtp_asserts (
    input wire logic                        mclk_i,
    input wire logic                        reset_n_i,
    input wire logic                        req,
    input wire logic                        wvalid,
    input wire logic [rtp_pkg::WADDR_W-1:0] waddr,
    input wire logic                        wlast
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // A taken request ends with a bare marker one edge later, or shows its first
    // word two edges later, because the slave registers its link outputs
    sequence s_taken; req && !wvalid; endsequence
    sequence s_empty_end; wlast; endsequence
    sequence s_first_word; ##1 wvalid; endsequence

    chk_req_answer: assert property (s_taken |=> s_empty_end or s_first_word)
        else $error("request not answered on the next cycle");
    chk_last_ends: assert property (wlast |=> !wvalid)
        else $error("word sent after the end marker");
    chk_addr_step: assert property (wvalid && !wlast |=> wvalid && waddr == $past(waddr) + 1'b1)
        else $error("words not back to back in ascending order");
    chk_first_addr: assert property ($rose(wvalid) |-> waddr == '0)
        else $error("transfer does not start at word zero");
    chk_start_cause: assert property ($rose(wvalid) |-> $past(req, 2))
        else $error("transfer started without a request");
    chk_req_pulse: assert property (req |=> !req)
        else $error("request longer than one cycle");
    chk_no_req_busy: assert property (wvalid |-> !req)
        else $error("request raised during a transfer");
    chk_lone_last: assert property (wlast && !wvalid |-> $past(req))
        else $error("empty transfer end without a request");
endmodule // rtp_asserts

// file: sim/remote_io_timeout_packer_test.sv
`timescale 1ns/1ps
// Drives both ends of the link and compares every word that crosses it
module remote_io_timeout_packer_test;
    logic         mclk_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic         smode = 1'b1, cen = 1'b0, brev = 1'b0;
    logic [8:0]   obytes = 9'h000;
    logic [6:0]   iword = 7'h00, owa = 7'h00, wa;
    logic [4:0]   scnt = 5'h00;
    logic [167:0] snum = '0;
    logic [127:0] sys = '0;
    logic         owr = 1'b0, start = 1'b0, sv = 1'b0, inv, wv, dn, sbusy, mbusy;
    logic [15:0]  owd = 16'h0000, sd = 16'h0000, ind, wd;
    logic [15:0]  area [128];
    int           fails = 0;
    int           num_checks = 0;

    always #12.5 mclk_i = ~mclk_i;

    rtp_link_if rtp_link_if_i ();
    rtp_slave rtp_slave_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_slave_mode_i(smode),
        .cfg_collect_en_i(cen), .cfg_bit_rev_i(brev), .cfg_out_bytes_i(obytes),
        .cfg_info_word_i(iword), .cfg_station_cnt_i(scnt), .cfg_station_num_i(snum),
        .sys_timeout_i(sys), .out_wr_i(owr), .out_wr_addr_i(owa), .out_wr_data_i(owd),
        .in_valid_o(inv), .in_data_o(ind), .busy_o(sbusy), .lnk(rtp_link_if_i));
    rtp_master rtp_master_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(start),
        .send_valid_i(sv), .send_data_i(sd), .busy_o(mbusy), .word_valid_o(wv),
        .word_addr_o(wa), .word_data_o(wd), .done_o(dn), .lnk(rtp_link_if_i));
    rtp_asserts rtp_asserts_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .req(rtp_link_if_i.req), .wvalid(rtp_link_if_i.wvalid),
        .waddr(rtp_link_if_i.waddr), .wlast(rtp_link_if_i.wlast));

    // Compare and count; a mismatch is reported at once
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [15:0] rv(input logic [15:0] w);
        for (int i = 0; i < 16; i++) rv[i] = w[15-i];
    endfunction

    // Expected word at index x, worked out from the bench's own copy of the area
    function automatic logic [15:0] expw(input int x);
        logic [31:0] st;
        int n, c, nw;
        st = '0;
        n = (obytes + 1) / 2;
        c = (scnt > 24) ? 24 : scnt;
        nw = (c > 16) ? 2 : 1;
        for (int k = 0; k < c; k++) st[k] = sys[snum[7*k +: 7]];
        expw = area[x];
        if (cen && smode && iword + nw <= n) begin
            if (x == iword) expw = st[15:0];
            if (nw == 2 && x == iword + 1) expw = st[31:16];
        end
        if (brev) expw = rv(expw);
    endfunction

    // One output transfer; a short gap first lets the master's done flag fall
    task automatic xfer(input logic [2:0] f, input logic [8:0] b, input logic [6:0] iw,
                        input logic [4:0] c);
        int got;
        int sbn;
        got = 0;
        sbn = 0;
        {smode, cen, brev, obytes, iword, scnt} = {f, b, iw, c};
        repeat (2) @(posedge mclk_i);
        @(posedge mclk_i) #1;
        start = 1'b1;
        @(posedge mclk_i) #1;
        start = 1'b0;
        chk("master_busy", {15'h0000, mbusy}, 16'h0001);
        for (int t = 0; t < 300 && !dn; t++) begin
            @(posedge mclk_i) #1;
            // Slave busy leads the master's copy of each word by one cycle
            if (sbusy) sbn++;
            if (wv) begin
                chk("word_addr", {9'h000, wa}, 16'(got));
                chk("word_data", wd, expw(got));
                got++;
            end
        end
        chk("done", {15'h0000, dn}, 16'h0001);
        chk("master_idle", {15'h0000, mbusy}, 16'h0000);
        chk("slave_busy", 16'(sbn), 16'((b + 1) / 2));
        chk("word_count", 16'(got), 16'((b + 1) / 2));
    endtask

    // One input word from master to slave, seen two cycles later
    task automatic snd(input logic [15:0] d);
        @(posedge mclk_i) #1;
        sv = 1'b1;
        sd = d;
        @(posedge mclk_i) #1;
        sv = 1'b0;
        @(posedge mclk_i) #1;
        chk("in_valid", {15'h0000, inv}, 16'h0001);
        chk("in_data", ind, brev ? rv(d) : d);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cut a hang short; the tests need well under 5000 cycles
    initial begin
        #(25 * 20000);
        fails++;
        print_verdict;
    end

    // Main sequence: odd station numbers, a mixed flag pattern, then the cases
    initial begin
        for (int k = 0; k < 24; k++) snum[7*k +: 7] = 7'(2 * k + 1);
        sys = {8{16'h6c3a}};
        repeat (12) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        for (int i = 0; i < 128; i++) begin
            @(posedge mclk_i) #1;
            area[i] = 16'(i * 16'h0205) ^ 16'h5a3c;
            owr = 1'b1;
            owa = 7'(i);
            owd = area[i]; // Area filled only from the controller side
        end
        @(posedge mclk_i) #1;
        owr = 1'b0;
        xfer(3'b110, 9'h008, 7'h01, 5'h03);
        xfer(3'b110, 9'h010, 7'h02, 5'h14);
        xfer(3'b110, 9'h010, 7'h02, 5'h10);
        xfer(3'b110, 9'h010, 7'h04, 5'h1f);
        xfer(3'b110, 9'h007, 7'h02, 5'h18);
        xfer(3'b110, 9'h100, 7'h7e, 5'h18);
        xfer(3'b110, 9'h100, 7'h7f, 5'h18);
        xfer(3'b010, 9'h008, 7'h01, 5'h03);
        xfer(3'b100, 9'h008, 7'h01, 5'h03);
        xfer(3'b110, 9'h000, 7'h00, 5'h03);
        sys = ~sys;
        xfer(3'b110, 9'h008, 7'h01, 5'h03);
        snd(16'h8c01);
        xfer(3'b111, 9'h010, 7'h01, 5'h18);
        snd(16'h8c01);
        print_verdict;
    end
endmodule // remote_io_timeout_packer_test
